// ==== core/ssf_status_flags.sv ====
`timescale 1ns/1ps
module ssf_status_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic baud_tick,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic rx_ack_done,
  input wire logic rx_overrun,
  input wire logic bit9_event,
  input wire logic tx_load,
  input wire logic rx_active,
  input wire logic first_byte,
  input wire logic direction_is_send,
  input wire logic is_master,
  input wire logic reserved_addr,
  input wire logic bus_fault_flag,
  output logic [7:0] tx_data,
  output logic scl_hold_low,
  output logic rx_irq,
  output logic tx_irq,
  output logic tx_idle_irq,
  output logic dma_mode,
  output logic rx_full_flag,
  output logic tx_empty_flag,
  output logic tx_bus_idle_flag,
  output logic overrun_flag
);
  localparam int FIFO_DEPTH_L = ssf_pkg::FIFO_DEPTH;

  // control register fields, plus the idle interrupt enable of the flags register
  logic rx_irq_allow;
  logic tx_irq_allow;
  logic wait_point_select;
  logic if_enable;
  logic fifo_en;
  logic fifo_rx_idle_irq_allow;
  logic [4:0] fifo_count_cfg;
  logic tx_idle_irq_allow;

  // receive holding register and fifo storage
  logic [7:0] rx_holding_reg;
  logic [7:0] fifo_mem [FIFO_DEPTH_L-1:0];
  logic [ssf_pkg::FIFO_AW-1:0] wr_ptr;
  logic [ssf_pkg::FIFO_AW-1:0] rd_ptr;
  logic [4:0] fifo_level;

  // idle count, ack stretch and scl bit tracking
  logic [3:0] idle_cnt;
  logic hold_ack;
  logic [2:0] scl_sync;
  logic scl_fell;
  logic bit_cnt_eight;
  logic [3:0] bit_cnt;

  // apb decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic rx_read;
  logic tx_write;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_push;
  logic fifo_pop;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == ssf_pkg::FLAGS_ADDR) | (paddr == ssf_pkg::CTRL_ADDR) |
                   (paddr == ssf_pkg::RXDATA_ADDR) | (paddr == ssf_pkg::TXDATA_ADDR);
  // zero wait state slave, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  // data register strobes
  assign rx_read = rd_en & (paddr == ssf_pkg::RXDATA_ADDR);
  assign tx_write = wr_en & (paddr == ssf_pkg::TXDATA_ADDR);
  // fifo level flags
  assign fifo_full = (fifo_level == 5'(ssf_pkg::FIFO_DEPTH));
  assign fifo_empty = (fifo_level == 5'h00);
  // overrun data is never stored
  assign fifo_push = fifo_en & rx_byte_valid & ~rx_overrun & ~fifo_full;
  assign fifo_pop = fifo_en & rx_read & ~fifo_empty;

  // scl edge detect, second and third stages differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync <= 3'h7; // idle high, no false edge after reset
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
    end
  end
  assign scl_fell = scl_sync[2] & ~scl_sync[1];

  // count data bits by falling scl while receiving
  // the ack fall wraps the count, so each byte starts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 4'h0;
    end else if (!rx_active) begin
      bit_cnt <= 4'h0;
    end else if (scl_fell && bit_cnt == 4'h8) begin
      bit_cnt <= 4'h0; // ninth fall ends the byte
    end else if (scl_fell) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  assign bit_cnt_eight = rx_active & scl_fell & (bit_cnt == 4'h7);

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_allow <= 1'b0;
      tx_irq_allow <= 1'b0;
      wait_point_select <= 1'b0;
      if_enable <= 1'b0;
      fifo_en <= 1'b0;
      fifo_rx_idle_irq_allow <= 1'b0;
      fifo_count_cfg <= 5'h01;
    end else if (wr_en && paddr == ssf_pkg::CTRL_ADDR) begin
      rx_irq_allow <= pwdata[ssf_pkg::RIE_BIT];
      tx_irq_allow <= pwdata[ssf_pkg::TIE_BIT];
      wait_point_select <= pwdata[ssf_pkg::WAIT_POINT_SELECT_BIT];
      if_enable <= pwdata[ssf_pkg::EN_BIT];
      fifo_en <= pwdata[ssf_pkg::FIFO_EN_BIT];
      fifo_rx_idle_irq_allow <= pwdata[ssf_pkg::FIFO_RX_IDLE_IRQ_ALLOW_BIT];
      fifo_count_cfg <= pwdata[ssf_pkg::CNT_LSB +: 5];
    end
  end

  // dma mode and idle interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_mode <= 1'b0;
      tx_idle_irq_allow <= 1'b0;
    end else if (wr_en && paddr == ssf_pkg::FLAGS_ADDR) begin
      if (!if_enable) begin
        dma_mode <= pwdata[ssf_pkg::DMA_BIT];
      end
      // forced zero while dma mode off
      tx_idle_irq_allow <= pwdata[ssf_pkg::IDLE_IRQ_BIT] & dma_mode;
    end else if (!dma_mode) begin
      tx_idle_irq_allow <= 1'b0;
    end
  end

  // overrun flag: event wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag <= 1'b0;
    end else if (rx_byte_valid && rx_overrun) begin
      overrun_flag <= 1'b1;
    end else if (wr_en && paddr == ssf_pkg::FLAGS_ADDR && pwdata[ssf_pkg::OVR_CLR_BIT]) begin
      overrun_flag <= 1'b0;
    end
  end

  // receive holding register and fifo storage
  always_ff @(posedge pclk) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr] <= rx_byte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_level <= 5'h00;
    end else if (!fifo_en) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_level <= 5'h00;
    end else begin
      if (fifo_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fifo_level <= fifo_level + {4'h0, fifo_push} - {4'h0, fifo_pop};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_reg <= 8'h00;
    end else if (!fifo_en && rx_byte_valid && !rx_overrun) begin
      rx_holding_reg <= rx_byte;
    end else if (fifo_pop) begin
      rx_holding_reg <= fifo_mem[rd_ptr];
    end
  end

  // idle counter on baud clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= 4'h0;
    end else if (rx_read || rx_byte_valid || !fifo_en || fifo_empty) begin
      idle_cnt <= 4'h0;
    end else if (baud_tick && idle_cnt <= ssf_pkg::IDLE_LIMIT) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // receive full flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag <= 1'b0;
    end else if (fifo_en) begin
      if (fifo_level >= fifo_count_cfg && fifo_count_cfg != 5'h00) begin
        rx_full_flag <= 1'b1;
      end else if (fifo_rx_idle_irq_allow && idle_cnt > ssf_pkg::IDLE_LIMIT &&
                   fifo_level < fifo_count_cfg && !bus_fault_flag) begin
        rx_full_flag <= 1'b1;
      end else if (fifo_empty || (fifo_pop && fifo_level == 5'h01)) begin
        rx_full_flag <= 1'b0;
      end
    end else if (bit_cnt_eight || (rx_byte_valid && !rx_overrun)) begin
      rx_full_flag <= 1'b1;
    end else if (rx_read) begin
      rx_full_flag <= 1'b0;
    end
  end

  // scl stretch after ack when wait point is the ninth bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ack <= 1'b0;
    end else if (!rx_full_flag) begin
      hold_ack <= 1'b0;
    end else if (rx_ack_done) begin
      hold_ack <= 1'b1;
    end
  end

  // transmit holding register and tx-empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= ssf_pkg::RST_TXDATA;
      tx_empty_flag <= ssf_pkg::RST_TXE;
    end else if (tx_load) begin
      tx_empty_flag <= 1'b1;
    end else if (wr_en && paddr == ssf_pkg::FLAGS_ADDR && pwdata[ssf_pkg::TX_FORCE_BIT]) begin
      tx_empty_flag <= 1'b1;
    end else if (tx_write && tx_empty_flag) begin
      tx_data <= pwdata[7:0];
      tx_empty_flag <= 1'b0;
    end
  end

  // transmit bus idle flag
  logic send_phase;
  logic tbi_set;
  assign send_phase = is_master | direction_is_send;
  assign tbi_set = (bit_cnt_eight && wait_point_select && send_phase && !first_byte &&
                    tx_empty_flag) ||
                   (bit9_event && tx_empty_flag &&
                    ((is_master && first_byte && !reserved_addr) ||
                     (!wait_point_select && send_phase && !first_byte))) ||
                   (dma_mode && wr_en && paddr == ssf_pkg::FLAGS_ADDR &&
                    pwdata[ssf_pkg::TX_FORCE_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bus_idle_flag <= ssf_pkg::RST_TBI;
    end else if (tbi_set) begin
      tx_bus_idle_flag <= 1'b1;
    end else if (tx_write) begin
      tx_bus_idle_flag <= 1'b0;
    end
  end

  // scl hold and interrupt requests, all but rx_irq selected by dma mode
  always_comb begin
    scl_hold_low = 1'b0;
    if (dma_mode) begin
      if (fifo_en) begin
        scl_hold_low = rx_active & fifo_full;
      end else if (rx_active && !first_byte && rx_full_flag) begin
        scl_hold_low = wait_point_select | hold_ack;
      end
      if (tx_bus_idle_flag && !first_byte && !rx_active) begin
        scl_hold_low = 1'b1;
      end
    end
  end
  // rx interrupt from data or overrun
  assign rx_irq = rx_irq_allow & (rx_full_flag | overrun_flag);
  // tx interrupts, normal or dma flavour
  assign tx_irq = tx_irq_allow & tx_empty_flag & ~dma_mode;
  assign tx_idle_irq = dma_mode & tx_idle_irq_allow & tx_bus_idle_flag;

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ssf_pkg::FLAGS_ADDR: prdata <= {16'h0000, 2'b00, dma_mode, tx_idle_irq_allow,
                                        overrun_flag, rx_full_flag, tx_empty_flag,
                                        tx_bus_idle_flag, 8'h00};
        ssf_pkg::CTRL_ADDR: prdata <= {19'h00000, fifo_count_cfg, 2'b00,
                                       fifo_rx_idle_irq_allow, fifo_en, if_enable,
                                       wait_point_select, tx_irq_allow, rx_irq_allow};
        ssf_pkg::RXDATA_ADDR: prdata <= {24'h000000,
                                         fifo_en ? fifo_mem[rd_ptr] : rx_holding_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== core/ssf_pkg.sv ====
package ssf_pkg;
  // apb register map (byte addresses)
  localparam logic [7:0] FLAGS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  localparam logic [7:0] RXDATA_ADDR = 8'h08;
  localparam logic [7:0] TXDATA_ADDR = 8'h0C;
  // flags register field positions
  localparam int OVR_CLR_BIT = 15;
  localparam int TX_FORCE_BIT = 14;
  localparam int DMA_BIT = 13;
  localparam int IDLE_IRQ_BIT = 12;
  localparam int OVR_BIT = 11;
  localparam int RXF_BIT = 10;
  localparam int TXE_BIT = 9;
  localparam int TBI_BIT = 8;
  // ctrl register field positions
  localparam int RIE_BIT = 0;
  localparam int TIE_BIT = 1;
  localparam int WAIT_POINT_SELECT_BIT = 2;
  localparam int EN_BIT = 3;
  localparam int FIFO_EN_BIT = 4;
  localparam int FIFO_RX_IDLE_IRQ_ALLOW_BIT = 5;
  localparam int CNT_LSB = 8;
  // reset values
  localparam logic RST_TXE = 1'b1;
  localparam logic RST_TBI = 1'b1;
  localparam logic [7:0] RST_TXDATA = 8'hFF;
  // receive fifo
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // idle detection: more than 8 baud clocks
  localparam logic [3:0] IDLE_LIMIT = 4'h8;
endpackage

// ==== verification/ssf_chk.sv ====
`timescale 1ns/1ps
// port-level timing checks of the flag block
module ssf_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_byte_valid,
  input wire logic rx_overrun,
  input wire logic tx_load,
  input wire logic scl_hold_low,
  input wire logic tx_idle_irq,
  input wire logic dma_mode,
  input wire logic tx_empty_flag,
  input wire logic tx_bus_idle_flag,
  input wire logic overrun_flag
);
  logic fwr;
  logic ov;
  // flags register write and overrun event
  assign fwr = psel && penable && pwrite && paddr == ssf_pkg::FLAGS_ADDR;
  assign ov = rx_byte_valid && rx_overrun;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OVR_CLR: assert property (fwr && pwdata[15] && !ov |=> !overrun_flag)
    else $error("overrun flag not cleared");
  AST_OVR_KEEP: assert property (fwr && !pwdata[15] && overrun_flag |=> overrun_flag)
    else $error("overrun flag lost on zero write");
  AST_OVR_SET: assert property (ov |=> overrun_flag [*2])
    else $error("overrun flag not set");
  AST_TX_FORCE: assert property (fwr && pwdata[14] |=> tx_empty_flag)
    else $error("tx empty not forced");
  AST_TBI_FORCE: assert property (fwr && pwdata[14] && dma_mode |=> tx_bus_idle_flag)
    else $error("tx bus idle not forced");
  AST_IDLE_IRQ: assert property (tx_idle_irq |-> dma_mode && tx_bus_idle_flag)
    else $error("idle irq without cause");
  AST_TX_LOAD: assert property (tx_load |=> tx_empty_flag)
    else $error("tx empty not set on load");
  AST_HOLD_DMA: assert property (scl_hold_low |-> dma_mode)
    else $error("scl held outside dma mode");
  // main scenarios
  cover property (tx_idle_irq);
  cover property (scl_hold_low && !tx_bus_idle_flag);
  cover property (ov);
endmodule

bind ssf_status_flags ssf_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .rx_byte_valid, .rx_overrun, .tx_load, .scl_hold_low, .tx_idle_irq, .dma_mode,
  .tx_empty_flag, .tx_bus_idle_flag, .overrun_flag);

// ==== verification/ssf_peer.sv ====
`timescale 1ns/1ps
// bus peer clocking one byte and ack slot over the link
module ssf_peer (
  input wire logic pclk,
  input wire logic hold,
  output logic scl_out,
  output logic rx_byte_valid,
  output logic bit9_event,
  output logic rx_ack_done,
  output logic [7:0] rx_byte
);
  // link idles high through its pull-up
  initial {scl_out, rx_byte_valid, bit9_event, rx_ack_done, rx_byte} = {4'h8, 8'hA5};
  // eight data bits then ack, low and high halves of 400 ns
  task automatic frame(input logic [7:0] b);
    for (int i = 1; i <= 9; i++) begin
      repeat (4) @(posedge pclk);
      scl_out <= 1'b0;
      @(posedge pclk);
      rx_byte <= b;
      rx_byte_valid <= (i == 8);
      bit9_event <= (i == 9);
      rx_ack_done <= (i == 9);
      @(posedge pclk);
      {rx_byte_valid, bit9_event, rx_ack_done} <= 3'h0;
      repeat (2) @(posedge pclk);
      while (hold) @(posedge pclk);
      scl_out <= 1'b1;
    end
    rx_byte <= ~b; // stale byte not shown
  endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// self-checking bench of the flag block
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic baud_tick = 1'b0;
  logic rx_overrun = 1'b0;
  logic tx_load = 1'b0;
  logic direction_is_send = 1'b0;
  logic rx_active = 1'b0;
  logic first_byte = 1'b0;
  logic is_master = 1'b0;
  logic reserved_addr = 1'b0;
  logic bus_fault_flag = 1'b0;
  logic [31:0] prdata;
  logic [7:0] tx_data, rx_byte, b;
  logic pready, pslverr, scl_hold_low, rx_irq, tx_irq, tx_idle_irq, dma_mode, rx_full_flag;
  logic tx_empty_flag, tx_bus_idle_flag, overrun_flag, peer_scl, rx_byte_valid;
  logic bit9_event, rx_ack_done;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int err_count = 0;
  int num_checks = 0;
  wire scl_line = peer_scl & ~scl_hold_low; // open-drain wire
  ssf_status_flags DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl_line), .baud_tick, .rx_byte, .rx_byte_valid, .rx_ack_done,
    .rx_overrun, .bit9_event, .tx_load, .rx_active, .first_byte, .direction_is_send,
    .is_master, .reserved_addr, .bus_fault_flag, .tx_data, .scl_hold_low, .rx_irq, .tx_irq,
    .tx_idle_irq, .dma_mode, .rx_full_flag, .tx_empty_flag, .tx_bus_idle_flag, .overrun_flag);
  ssf_peer peer (.pclk, .hold(scl_hold_low), .scl_out(peer_scl), .rx_byte_valid,
    .bit9_event, .rx_ack_done, .rx_byte);
  // clock and baud ticks
  always #50 pclk = ~pclk;
  always @(posedge pclk) baud_tick <= ~baud_tick;
  task cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_lv(input logic got, input logic exp);
    cmp_rd({32'h0, got}, {32'h0, exp});
  endtask
  // read monitor takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      cmp_rd({pslverr, prdata & mq[0]}, eq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    summarize;
  end
  initial begin
    void'($urandom(32'h4561d3fe));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h300, 32'hFF00);
    rd(8'h04, 33'h100, 32'h1F3F);
    rd(8'h10, 33'h100000000, 32'h0);
    tend("reset");
    rx_overrun <= 1'b1;
    peer.frame(8'($urandom));
    rx_overrun <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 33'h800, 32'hC800);
    apb(1'b1, 8'h04, 32'h103);
    cmp_lv(rx_irq, 1'b1);
    cmp_lv(tx_irq, 1'b1);
    apb(1'b1, 8'h00, 32'h8000);
    rd(8'h00, 33'h0, 32'hC800);
    tend("overrun");
    b = 8'($urandom);
    peer.frame(b);
    cmp_lv(rx_full_flag, 1'b1);
    cmp_lv(rx_irq, 1'b1);
    rd(8'h08, {25'h0, b}, 32'hFF);
    cmp_lv(rx_full_flag, 1'b0);
    apb(1'b1, 8'h00, 32'h1000);
    rd(8'h00, 33'h0, 32'h1000);
    tend("receive");
    direction_is_send <= 1'b1;
    apb(1'b1, 8'h00, 32'h2000);
    apb(1'b1, 8'h00, 32'h3000);
    rd(8'h00, 33'h3000, 32'h3000);
    b = 8'($urandom);
    apb(1'b1, 8'h0C, {24'h0, b});
    cmp_lv(tx_empty_flag, 1'b0);
    cmp_lv(tx_bus_idle_flag, 1'b0);
    cmp_rd({25'h0, tx_data}, {25'h0, b});
    tx_load <= 1'b1;
    @(posedge pclk);
    tx_load <= 1'b0;
    @(posedge pclk);
    cmp_lv(tx_empty_flag, 1'b1);
    apb(1'b1, 8'h0C, 32'h5A);
    apb(1'b1, 8'h00, 32'h7000);
    cmp_lv(tx_bus_idle_flag, 1'b1);
    cmp_lv(tx_idle_irq, 1'b1);
    cmp_lv(scl_hold_low, 1'b1);
    rd(8'h00, 33'h0, 32'hC000);
    apb(1'b1, 8'h0C, 32'h3C);
    cmp_lv(scl_hold_low, 1'b0);
    cmp_lv(tx_idle_irq, 1'b0);
    direction_is_send <= 1'b0;
    tend("dma transmit");
    apb(1'b1, 8'h04, 32'h108);
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h00, 33'h2000, 32'h2000);
    rx_active <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      b = 8'($urandom);
      apb(1'b1, 8'h04, 32'h100 | (32'(w) << 2));
      fork
        peer.frame(b);
        begin
          wait (scl_hold_low === 1'b1);
          cmp_lv(rx_full_flag, 1'b1);
          @(posedge pclk);
          rd(8'h08, {25'h0, b}, 32'hFF);
          cmp_lv(scl_hold_low, 1'b0);
        end
      join
    end
    rx_active <= 1'b0;
    tend("dma stretch");
    summarize;
  end
endmodule
